// ==== hdl/tbl_pkg.sv ====
// Purpose: shared constants, types and decode for the program memory table access block
// Assumes: 32-bit AXI4-Lite register bus, byte offsets below are byte addresses
// Notes:   register offsets, field positions, pointer widths and the pointer and latch reset values live here
package tbl_pkg;

	// register map (byte addresses)
	localparam int          AXI_AW          = 8;
	localparam logic [7:0]  OFS_LATCH       = 8'h00;
	localparam logic [7:0]  OFS_PTR_LOW     = 8'h04;
	localparam logic [7:0]  OFS_PTR_HIGH    = 8'h08;
	localparam logic [7:0]  OFS_PTR_UPPER   = 8'h0C;
	localparam logic [7:0]  OFS_CMD         = 8'h10;
	localparam logic [7:0]  OFS_STATUS      = 8'h14;

	// pointer geometry
	localparam int          PTR_W           = 22;
	localparam int          LOW_W           = 21;
	localparam int          UPPER_W         = 6;
	localparam int          ERASE_LSB       = 6;
	localparam int          HOLD_BYTES_DEF  = 32;

	// reset values
	localparam logic [21:0] PTR_RST         = 22'h000000;
	localparam logic [7:0]  LATCH_RST       = 8'h00;

	// command register fields
	localparam int          CMD_MODE_LSB    = 0;
	localparam int          CMD_OP_LSB      = 2;

	// status register fields
	localparam int          STAT_BUSY_BIT    = 0;
	localparam int          STAT_REFUSED_BIT = 1;

	// bus responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_STAGE   = 2'h1,
		OP_PROGRAM = 2'h2,
		OP_ERASE   = 2'h3
	} op_e;

	typedef enum logic [1:0] {
		MODE_KEEP    = 2'h0,
		MODE_POSTINC = 2'h1,
		MODE_POSTDEC = 2'h2,
		MODE_PREINC  = 2'h3
	} mode_e;

	typedef struct packed {
		op_e   op;
		mode_e mode;
	} cmd_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} reg_wr_s;

	// true when the byte address names an implemented register
	function automatic logic reg_mapped(input logic [7:0] a);
		return (a == OFS_LATCH) || (a == OFS_PTR_LOW) || (a == OFS_PTR_HIGH) ||
		       (a == OFS_PTR_UPPER) || (a == OFS_CMD) || (a == OFS_STATUS);
	endfunction

endpackage

// ==== hdl/ptr_step.sv ====
// Purpose: access address and next pointer for one table operation
// Assumes: pure combinational, same clock domain as the caller
// Notes:   only the low 21 bits ever count, the top bit is carried through
`timescale 1ns/1ps
module ptr_step (
	input  wire logic [21:0]        ptr_i,
	input  wire tbl_pkg::mode_e     mode_i,
	output logic      [21:0]        access_o,
	output logic      [21:0]        next_o
);
	logic [21:0] inc;
	logic [21:0] dec;

	always_comb begin
		inc = {ptr_i[tbl_pkg::PTR_W-1], ptr_i[tbl_pkg::LOW_W-1:0] + 21'h000001};
		dec = {ptr_i[tbl_pkg::PTR_W-1], ptr_i[tbl_pkg::LOW_W-1:0] - 21'h000001};
		case (mode_i)
			tbl_pkg::MODE_KEEP: begin
				access_o = ptr_i;
				next_o   = ptr_i;
			end
			tbl_pkg::MODE_POSTINC: begin
				access_o = ptr_i;
				next_o   = inc;
			end
			tbl_pkg::MODE_POSTDEC: begin
				access_o = ptr_i;
				next_o   = dec;
			end
			tbl_pkg::MODE_PREINC: begin
				access_o = inc;
				next_o   = inc;
			end
			default: begin
				access_o = ptr_i;
				next_o   = ptr_i;
			end
		endcase
	end
endmodule

// ==== hdl/axil_slave.sv ====
// Purpose: AXI4-Lite slave front end, one write and one read under way at most
// Assumes: registers are 8 bits wide in byte lane 0 of each aligned word
// Notes:   write lands one cycle after both halves are held, read data two cycles after ar
`timescale 1ns/1ps
module axil_slave (
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 ce_i,
	input  wire logic [7:0]           awaddr_i,
	input  wire logic                 awvalid_i,
	output logic                      awready_o,
	input  wire logic [31:0]          wdata_i,
	input  wire logic [3:0]           wstrb_i,
	input  wire logic                 wvalid_i,
	output logic                      wready_o,
	output logic      [1:0]           bresp_o,
	output logic                      bvalid_o,
	input  wire logic                 bready_i,
	input  wire logic [7:0]           araddr_i,
	input  wire logic                 arvalid_i,
	output logic                      arready_o,
	output logic      [31:0]          rdata_o,
	output logic      [1:0]           rresp_o,
	output logic                      rvalid_o,
	input  wire logic                 rready_i,
	output tbl_pkg::reg_wr_s          wr_o,
	output logic                      wr_valid_o,
	output logic      [7:0]           rd_addr_o,
	input  wire logic [7:0]           rd_data_i
);
	logic             aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic             awready_q, awready_d, wready_q, wready_d;
	logic             bvalid_q, bvalid_d, wr_valid_q, wr_valid_d;
	logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]       awaddr_q, awaddr_d, araddr_q, araddr_d;
	logic [31:0]      wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]       wstrb_q, wstrb_d;
	tbl_pkg::reg_wr_s wr_q, wr_d;
	logic             arready_q, arready_d, ar_pend_q, ar_pend_d, rvalid_q, rvalid_d;

	// write channels taken in either order, response after both
	always_comb begin
		aw_held_d  = aw_held_q | (awvalid_i & awready_q);
		w_held_d   = w_held_q | (wvalid_i & wready_q);
		awaddr_d   = (awvalid_i & awready_q) ? awaddr_i : awaddr_q;
		wdata_d    = (wvalid_i & wready_q) ? wdata_i : wdata_q;
		wstrb_d    = (wvalid_i & wready_q) ? wstrb_i : wstrb_q;
		bvalid_d   = bvalid_q & ~bready_i;
		bresp_d    = bresp_q;
		wr_d       = wr_q;
		wr_valid_d = 1'b0;
		if (aw_held_d && w_held_d && !bvalid_q) begin
			wr_d       = '{addr: awaddr_d, data: wdata_d, strb: wstrb_d};
			wr_valid_d = tbl_pkg::reg_mapped(awaddr_d);
			bresp_d    = tbl_pkg::reg_mapped(awaddr_d) ? tbl_pkg::RESP_OKAY : tbl_pkg::RESP_SLVERR;
			bvalid_d   = 1'b1;
			aw_held_d  = 1'b0;
			w_held_d   = 1'b0;
		end
		awready_d = ~aw_held_d & ~bvalid_d;
		wready_d  = ~w_held_d & ~bvalid_d;
	end

	// read: address held one cycle, then data registered
	always_comb begin
		ar_pend_d = ar_pend_q;
		araddr_d  = araddr_q;
		rvalid_d  = rvalid_q & ~rready_i;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (arvalid_i && arready_q) begin
			ar_pend_d = 1'b1;
			araddr_d  = araddr_i;
		end else if (ar_pend_q) begin
			ar_pend_d = 1'b0;
			rvalid_d  = 1'b1;
			rdata_d   = tbl_pkg::reg_mapped(araddr_q) ? {24'h000000, rd_data_i} : 32'h00000000;
			rresp_d   = tbl_pkg::reg_mapped(araddr_q) ? tbl_pkg::RESP_OKAY : tbl_pkg::RESP_SLVERR;
		end
		arready_d = ~ar_pend_d & ~rvalid_d;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_held_q  <= 1'b0;
			w_held_q   <= 1'b0;
			awready_q  <= 1'b1;
			wready_q   <= 1'b1;
			awaddr_q   <= 8'h00;
			wdata_q    <= 32'h00000000;
			wstrb_q    <= 4'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= 2'h0;
			wr_q       <= '0;
			wr_valid_q <= 1'b0;
			arready_q  <= 1'b1;
			ar_pend_q  <= 1'b0;
			araddr_q   <= 8'h00;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h00000000;
			rresp_q    <= 2'h0;
		end else if (ce_i) begin
			aw_held_q  <= aw_held_d;
			w_held_q   <= w_held_d;
			awready_q  <= awready_d;
			wready_q   <= wready_d;
			awaddr_q   <= awaddr_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			wr_q       <= wr_d;
			wr_valid_q <= wr_valid_d;
			arready_q  <= arready_d;
			ar_pend_q  <= ar_pend_d;
			araddr_q   <= araddr_d;
			rvalid_q   <= rvalid_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
		end
	end

	assign awready_o  = awready_q;
	assign wready_o   = wready_q;
	assign bvalid_o   = bvalid_q;
	assign bresp_o    = bresp_q;
	assign arready_o  = arready_q;
	assign rvalid_o   = rvalid_q;
	assign rdata_o    = rdata_q;
	assign rresp_o    = rresp_q;
	assign wr_o       = wr_q;
	assign wr_valid_o = wr_valid_q;
	assign rd_addr_o  = araddr_q;
endmodule

// ==== hdl/program_memory_table_access.sv ====
// Purpose: table read, stage, program and erase path between core registers and flash
// Assumes: flash port is synchronous logic on mclk_i; registers over AXI4-Lite
// Notes:   HOLD_BYTES must be 8, 16 or 32
`timescale 1ns/1ps
module program_memory_table_access #(
	parameter int HOLD_BYTES = tbl_pkg::HOLD_BYTES_DEF
) (
	input  wire logic                    mclk_i,
	input  wire logic                    rstn_i,
	input  wire logic                    ce_i,
	input  wire logic [7:0]              awaddr_i,
	input  wire logic                    awvalid_i,
	output logic                         awready_o,
	input  wire logic [31:0]             wdata_i,
	input  wire logic [3:0]              wstrb_i,
	input  wire logic                    wvalid_i,
	output logic                         wready_o,
	output logic      [1:0]              bresp_o,
	output logic                         bvalid_o,
	input  wire logic                    bready_i,
	input  wire logic [7:0]              araddr_i,
	input  wire logic                    arvalid_i,
	output logic                         arready_o,
	output logic      [31:0]             rdata_o,
	output logic      [1:0]              rresp_o,
	output logic                         rvalid_o,
	input  wire logic                    rready_i,
	output logic      [21:0]             pm_addr_o,
	output logic                         pm_read_o,
	input  wire logic [7:0]              pm_rdata_i,
	input  wire logic                    pm_rvalid_i,
	output logic                         pm_program_o,
	output logic                         pm_erase_o,
	input  wire logic                    pm_done_i,
	output logic      [HOLD_BYTES*8-1:0] hold_block_o
);
	localparam int OFF_W = $clog2(HOLD_BYTES);

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_READ   = 2'h1,
		ST_COMMIT = 2'h2
	} state_e;

	tbl_pkg::reg_wr_s wr;
	logic             wr_valid;
	logic [7:0]       rd_addr;
	logic [7:0]       rd_data;

	state_e           state_q, state_d;
	logic [21:0]      ptr_q, ptr_d;
	logic [7:0]       latch_q, latch_d;
	tbl_pkg::cmd_s    cmd_q, cmd_d;
	logic             refused_q, refused_d;
	logic [21:0]      pm_addr_q, pm_addr_d;
	logic             pm_read_q, pm_read_d;
	logic             pm_program_q, pm_program_d;
	logic             pm_erase_q, pm_erase_d;
	logic             stage_en;
	logic [OFF_W-1:0] stage_idx;
	logic [21:0]      access_addr;
	logic [21:0]      next_ptr;
	logic             cmd_wr;
	tbl_pkg::cmd_s    cmd_new;
	logic             ptr_adv;
	logic             latch_load;
	logic             refused_clr;
	logic             busy;

	logic [HOLD_BYTES-1:0][7:0] hold_q, hold_d;

	// lane 0 write aimed at one register
	function automatic logic sw_hit(input tbl_pkg::reg_wr_s w, input logic v, input logic [7:0] ofs);
		return v && w.strb[0] && (w.addr == ofs);
	endfunction

	axil_slave u_bus (
		.mclk_i     (mclk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.awaddr_i   (awaddr_i),
		.awvalid_i  (awvalid_i),
		.awready_o  (awready_o),
		.wdata_i    (wdata_i),
		.wstrb_i    (wstrb_i),
		.wvalid_i   (wvalid_i),
		.wready_o   (wready_o),
		.bresp_o    (bresp_o),
		.bvalid_o   (bvalid_o),
		.bready_i   (bready_i),
		.araddr_i   (araddr_i),
		.arvalid_i  (arvalid_i),
		.arready_o  (arready_o),
		.rdata_o    (rdata_o),
		.rresp_o    (rresp_o),
		.rvalid_o   (rvalid_o),
		.rready_i   (rready_i),
		.wr_o       (wr),
		.wr_valid_o (wr_valid),
		.rd_addr_o  (rd_addr),
		.rd_data_i  (rd_data)
	);

	assign cmd_wr      = sw_hit(wr, wr_valid, tbl_pkg::OFS_CMD);
	assign refused_clr = sw_hit(wr, wr_valid, tbl_pkg::OFS_STATUS) && wr.data[tbl_pkg::STAT_REFUSED_BIT];
	assign busy        = (state_q != ST_IDLE);
	assign cmd_new = '{op: tbl_pkg::op_e'(wr.data[tbl_pkg::CMD_OP_LSB +: 2]),
	                   mode: tbl_pkg::mode_e'(wr.data[tbl_pkg::CMD_MODE_LSB +: 2])};

	ptr_step u_step (
		.ptr_i    (ptr_q),
		.mode_i   (cmd_new.mode),
		.access_o (access_addr),
		.next_o   (next_ptr)
	);

	// register reads
	always_comb begin
		case (rd_addr)
			tbl_pkg::OFS_LATCH:     rd_data = latch_q;
			tbl_pkg::OFS_PTR_LOW:   rd_data = ptr_q[7:0];
			tbl_pkg::OFS_PTR_HIGH:  rd_data = ptr_q[15:8];
			tbl_pkg::OFS_PTR_UPPER: rd_data = {2'h0, ptr_q[21:16]};
			tbl_pkg::OFS_CMD:       rd_data = {4'h0, cmd_q};
			tbl_pkg::OFS_STATUS: begin
				rd_data = 8'h00;
				rd_data[tbl_pkg::STAT_BUSY_BIT]    = busy;
				rd_data[tbl_pkg::STAT_REFUSED_BIT] = refused_q;
			end
			default:                rd_data = 8'h00;
		endcase
	end

	// software writes to pointer and latch, then table operation results
	always_comb begin
		ptr_d   = ptr_q;
		latch_d = latch_q;
		if (sw_hit(wr, wr_valid, tbl_pkg::OFS_LATCH)) begin
			latch_d = wr.data[7:0];
		end
		if (sw_hit(wr, wr_valid, tbl_pkg::OFS_PTR_LOW)) begin
			ptr_d[7:0] = wr.data[7:0];
		end
		if (sw_hit(wr, wr_valid, tbl_pkg::OFS_PTR_HIGH)) begin
			ptr_d[15:8] = wr.data[7:0];
		end
		if (sw_hit(wr, wr_valid, tbl_pkg::OFS_PTR_UPPER)) begin
			ptr_d[21:16] = wr.data[tbl_pkg::UPPER_W-1:0];
		end
		if (ptr_adv) begin
			ptr_d = next_ptr;
		end
		if (latch_load) begin
			latch_d = pm_rdata_i;
		end
	end

	// last accepted command and refusal flag, a refusal beats a clear
	always_comb begin
		cmd_d     = cmd_q;
		refused_d = refused_q & ~refused_clr;
		if (cmd_wr && !busy) begin
			cmd_d = cmd_new;
		end
		if (cmd_wr && busy) begin
			refused_d = 1'b1;
		end
	end

	// command sequencer and flash strobes
	always_comb begin
		state_d      = state_q;
		pm_addr_d    = pm_addr_q;
		pm_read_d    = 1'b0;
		pm_program_d = 1'b0;
		pm_erase_d   = 1'b0;
		stage_en     = 1'b0;
		ptr_adv      = 1'b0;
		latch_load   = 1'b0;
		stage_idx    = access_addr[OFF_W-1:0];
		case (state_q)
			ST_IDLE: begin
				if (cmd_wr) begin
					case (cmd_new.op)
						tbl_pkg::OP_READ: begin
							pm_addr_d = access_addr;
							pm_read_d = 1'b1;
							ptr_adv   = 1'b1;
							state_d   = ST_READ;
						end
						tbl_pkg::OP_STAGE: begin
							stage_en = 1'b1;
							ptr_adv  = 1'b1;
						end
						tbl_pkg::OP_PROGRAM: begin
							pm_addr_d    = {ptr_q[21:OFF_W], {OFF_W{1'b0}}};
							pm_program_d = 1'b1;
							state_d      = ST_COMMIT;
						end
						tbl_pkg::OP_ERASE: begin
							pm_addr_d  = {ptr_q[21:tbl_pkg::ERASE_LSB], 6'h00};
							pm_erase_d = 1'b1;
							state_d    = ST_COMMIT;
						end
						default: begin
						end
					endcase
				end
			end
			ST_READ: begin
				if (pm_rvalid_i) begin
					latch_load = 1'b1;
					state_d    = ST_IDLE;
				end
			end
			ST_COMMIT: begin
				if (pm_done_i)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// holding block entries, one per byte
	genvar gi;
	generate
		for (gi = 0; gi < HOLD_BYTES; gi++) begin : g_hold
			always_comb begin
				hold_d[gi] = (stage_en && stage_idx == OFF_W'(gi)) ? latch_q : hold_q[gi];
			end
		end
	endgenerate

	// sequencer state and flash strobes
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q      <= ST_IDLE;
			pm_addr_q    <= tbl_pkg::PTR_RST;
			pm_read_q    <= 1'b0;
			pm_program_q <= 1'b0;
			pm_erase_q   <= 1'b0;
		end else if (ce_i) begin
			state_q      <= state_d;
			pm_addr_q    <= pm_addr_d;
			pm_read_q    <= pm_read_d;
			pm_program_q <= pm_program_d;
			pm_erase_q   <= pm_erase_d;
		end
	end

	// command and refusal flag
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_q     <= '0;
			refused_q <= 1'b0;
		end else if (ce_i) begin
			cmd_q     <= cmd_d;
			refused_q <= refused_d;
		end
	end

	// pointer and transfer latch
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q   <= tbl_pkg::PTR_RST;
			latch_q <= tbl_pkg::LATCH_RST;
		end else if (ce_i) begin
			ptr_q   <= ptr_d;
			latch_q <= latch_d;
		end
	end

	// holding block
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_q <= '0;
		end else if (ce_i) begin
			hold_q <= hold_d;
		end
	end

	assign pm_addr_o    = pm_addr_q;
	assign pm_read_o    = pm_read_q;
	assign pm_program_o = pm_program_q;
	assign pm_erase_o   = pm_erase_q;
	assign hold_block_o = hold_q;
endmodule

// ==== tb/tbl_properties.sv ====
// Purpose: concurrent checks on the table access block ports
// Assumes: one clock domain; checks rest while ce_i is low
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
module tbl_properties #(
	parameter int HOLD_BYTES = 32
) (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic        arvalid_i,
	input  wire logic        arready_o,
	input  wire logic        rready_i,
	input  wire logic        rvalid_o,
	input  wire logic [31:0] rdata_o,
	input  wire logic        bready_i,
	input  wire logic        bvalid_o,
	input  wire logic [1:0]  bresp_o,
	input  wire logic [21:0] pm_addr_o,
	input  wire logic        pm_read_o,
	input  wire logic        pm_program_o,
	input  wire logic        pm_erase_o
);
	localparam int OFF = $clog2(HOLD_BYTES);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i || !ce_i);
	a_read_one_pulse: assert property (pm_read_o |=> !pm_read_o)
		else $error("read strobe longer than one cycle");
	a_one_op_kind: assert property ($onehot0({pm_read_o, pm_program_o, pm_erase_o}))
		else $error("two flash strobes at once");
	a_program_aligned: assert property (pm_program_o |-> pm_addr_o[OFF-1:0] == '0)
		else $error("program address not block aligned");
	a_erase_aligned: assert property (pm_erase_o |-> pm_addr_o[5:0] == 6'h00)
		else $error("erase address not on 64 byte block");
	a_addr_on_op: assert property ($changed(pm_addr_o) |-> (pm_read_o || pm_program_o || pm_erase_o))
		else $error("flash address moved without a strobe");
	a_rdata_upper_zero: assert property (rvalid_o |-> rdata_o[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_rvalid_holds: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped before accepted");
	a_bresp_holds: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped before accepted");
	a_read_latency: assert property (arvalid_i && arready_o |-> ##2 rvalid_o)
		else $error("read answer not two cycles after address");
endmodule

bind program_memory_table_access tbl_properties #(.HOLD_BYTES(HOLD_BYTES)) chk_u (.mclk_i, .rstn_i, .ce_i,
	.arvalid_i, .arready_o, .rready_i, .rvalid_o, .rdata_o, .bready_i, .bvalid_o, .bresp_o,
	.pm_addr_o, .pm_read_o, .pm_program_o, .pm_erase_o);

// ==== tb/flash_model.sv ====
// Purpose: behavioural flash partner answering reads, programs and erases
// Assumes: an answer comes the cycle after a strobe at the earliest
// Notes:   slow_i stretches every answer to eight cycles
`timescale 1ns/1ps
module flash_model (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic [21:0] pm_addr_i,
	input  wire logic        pm_read_i,
	input  wire logic        pm_program_i,
	input  wire logic        pm_erase_i,
	input  wire logic        slow_i,
	output logic      [7:0]  pm_rdata_o,
	output logic             pm_rvalid_o,
	output logic             pm_done_o
);
	logic [3:0] cnt_q;
	logic       busy_q;
	logic       rd_q;
	logic [7:0] byte_q;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			rd_q <= 1'b0;
			byte_q <= 8'h00;
			pm_rdata_o <= 8'h00;
			pm_rvalid_o <= 1'b0;
			pm_done_o <= 1'b0;
		end else begin
			pm_rvalid_o <= 1'b0;
			pm_done_o <= 1'b0;
			pm_rdata_o <= ~pm_rdata_o;
			if (pm_read_i || pm_program_i || pm_erase_i) begin
				busy_q <= 1'b1;
				rd_q <= pm_read_i;
				cnt_q <= slow_i ? 4'h7 : 4'h0;
				byte_q <= pm_addr_i[7:0] ^ {pm_addr_i[21], pm_addr_i[20:14]};
			end else if (busy_q && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				pm_rvalid_o <= rd_q;
				pm_done_o <= !rd_q;
				if (rd_q)
					pm_rdata_o <= byte_q;
			end
		end
	end
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the table access block
// Assumes: flash partner in flash_model, holding block of 16 bytes
// Notes:   registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
	localparam int HB = 16;
	logic        mclk_i, rstn_i, ce_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, slow;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pm_read_o, pm_rvalid_i;
	logic        pm_program_o, pm_erase_o, pm_done_i;
	logic [7:0]  awaddr_i, araddr_i, pm_rdata_i;
	logic [31:0] wdata_i, rdata_o;
	logic [3:0]  wstrb_i;
	logic [1:0]  bresp_o, rresp_o;
	logic [21:0] pm_addr_o, seen_addr;
	logic [2:0]  seen_kind;
	logic [HB*8-1:0] hold_block_o;
	int          bad_count = 0;
	int          tests_run = 0;
	program_memory_table_access #(.HOLD_BYTES(HB)) dut_u (.mclk_i, .rstn_i, .ce_i, .awaddr_i, .awvalid_i,
		.awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
		.arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .pm_addr_o, .pm_read_o,
		.pm_rdata_i, .pm_rvalid_i, .pm_program_o, .pm_erase_o, .pm_done_i, .hold_block_o);
	flash_model flash_u (.mclk_i, .rstn_i, .pm_addr_i(pm_addr_o), .pm_read_i(pm_read_o),
		.pm_program_i(pm_program_o), .pm_erase_i(pm_erase_o), .slow_i(slow), .pm_rdata_o(pm_rdata_i),
		.pm_rvalid_o(pm_rvalid_i), .pm_done_o(pm_done_i));
	always @(posedge mclk_i) begin
		if (pm_read_o || pm_program_o || pm_erase_o) begin
			seen_addr <= pm_addr_o;
			seen_kind <= {pm_erase_o, pm_program_o, pm_read_o};
		end
	end
	function automatic logic [7:0] fdata(input logic [21:0] a);
		return a[7:0] ^ {a[21], a[20:14]};
	endfunction
	function automatic logic [21:0] inc(input logic [21:0] p);
		return {p[21], p[20:0] + 21'h1};
	endfunction
	function automatic logic [21:0] dec(input logic [21:0] p);
		return {p[21], p[20:0] - 21'h1};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		$display("[FAIL] t=%0t wait limit reached", $time);
		end_sim();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge mclk_i);
		awaddr_i <= a;
		wdata_i <= d;
		wstrb_i <= 4'hF;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk_i);
			if (awvalid_i && awready_o)
				awvalid_i <= 1'b0;
			if (wvalid_i && wready_o)
				wvalid_i <= 1'b0;
			if (bvalid_o && bready_i)
				break;
		end
		if (n == 50)
			hang();
		r = bresp_o;
		bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge mclk_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk_i);
			if (arvalid_i && arready_o)
				arvalid_i <= 1'b0;
			if (rvalid_o && rready_i)
				break;
		end
		if (n == 50)
			hang();
		d = rdata_o;
		r = rresp_o;
		rready_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		`CHK(r, tbl_pkg::RESP_OKAY);
	endtask
	task automatic get_ptr(output logic [21:0] p);
		logic [31:0] lo, hi, up;
		logic [1:0]  r;
		rd(tbl_pkg::OFS_PTR_LOW, lo, r);
		rd(tbl_pkg::OFS_PTR_HIGH, hi, r);
		rd(tbl_pkg::OFS_PTR_UPPER, up, r);
		p = {up[5:0], hi[7:0], lo[7:0]};
	endtask
	task automatic wait_idle();
		logic [31:0] d;
		logic [1:0]  r;
		for (int n = 0; n < 40; n++) begin
			rd(tbl_pkg::OFS_STATUS, d, r);
			if (d[0] === 1'b0)
				return;
		end
		hang();
	endtask
	task automatic run_op(input logic [21:0] p, input tbl_pkg::op_e o, input tbl_pkg::mode_e m);
		wr(tbl_pkg::OFS_PTR_LOW, {24'h0, p[7:0]});
		wr(tbl_pkg::OFS_PTR_HIGH, {24'h0, p[15:8]});
		wr(tbl_pkg::OFS_PTR_UPPER, {26'h0, p[21:16]});
		wr(tbl_pkg::OFS_CMD, {28'h0, o, m});
		wait_idle();
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [21:0] p, acc, nxt;
		{rstn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, slow} <= 7'h00;
		ce_i <= 1'b1;
		awaddr_i <= 8'h00;
		araddr_i <= 8'h00;
		wdata_i <= 32'h0;
		wstrb_i <= 4'h0;
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'b1;
		rd(tbl_pkg::OFS_LATCH, d, r);
		`CHK({r, d}, {tbl_pkg::RESP_OKAY, 32'h0});
		get_ptr(p);
		`CHK(p, tbl_pkg::PTR_RST);
		axi_wr(8'h18, 32'h1, r);
		`CHK(r, tbl_pkg::RESP_SLVERR);
		rd(8'h18, d, r);
		`CHK({r, d}, {tbl_pkg::RESP_SLVERR, 32'h0});
		$display("test reset and map done");
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				slow <= (s == 1);
				p = s ? 22'h200000 : 22'h3FFFFF;
				acc = (m == 3) ? inc(p) : p;
				nxt = (m == 0) ? p : (m == 2) ? dec(p) : inc(p);
				run_op(p, tbl_pkg::OP_READ, tbl_pkg::mode_e'(m));
				`CHK(seen_addr, acc);
				rd(tbl_pkg::OFS_LATCH, d, r);
				`CHK(d[7:0], fdata(acc));
				get_ptr(p);
				`CHK(p, nxt);
			end
		end
		$display("test read modes done");
		wr(tbl_pkg::OFS_LATCH, 32'hA5);
		rd(tbl_pkg::OFS_LATCH, d, r);
		`CHK(d, 32'hA5);
		run_op(22'h2ABCDE, tbl_pkg::OP_STAGE, tbl_pkg::MODE_POSTINC);
		`CHK(hold_block_o[8*14 +: 8], 8'hA5);
		`CHK(hold_block_o[8*15 +: 8], 8'h00);
		get_ptr(p);
		`CHK(p, 22'h2ABCDF);
		wr(tbl_pkg::OFS_LATCH, 32'h3C);
		run_op(22'h2ABCDF, tbl_pkg::OP_STAGE, tbl_pkg::MODE_PREINC);
		`CHK(hold_block_o[7:0], 8'h3C);
		$display("test stage done");
		run_op(22'h2ABCDE, tbl_pkg::OP_PROGRAM, tbl_pkg::MODE_POSTDEC);
		`CHK({seen_kind, seen_addr}, {3'b010, 22'h2ABCD0});
		get_ptr(p);
		`CHK(p, 22'h2ABCDE);
		wr(tbl_pkg::OFS_CMD, {28'h0, tbl_pkg::OP_ERASE, tbl_pkg::MODE_KEEP});
		wr(tbl_pkg::OFS_CMD, {28'h0, tbl_pkg::OP_READ, tbl_pkg::MODE_KEEP});
		rd(tbl_pkg::OFS_STATUS, d, r);
		`CHK(d[1], 1'b1);
		wait_idle();
		`CHK({seen_kind, seen_addr}, {3'b100, 22'h2ABCC0});
		rd(tbl_pkg::OFS_CMD, d, r);
		`CHK(d, 32'hC);
		wr(tbl_pkg::OFS_STATUS, 32'h2);
		rd(tbl_pkg::OFS_STATUS, d, r);
		`CHK(d, 32'h0);
		$display("test program and erase done");
		end_sim();
	end
endmodule
